//--- include/oacrb_pkg.sv
// Purpose: constants and carriers for the amplifier control register bank
// Assumes: 32-bit axi4-lite register bus, one byte-wide register per word
// Notes: register offsets are word indexes; the byte address is four times the index
package oacrb_pkg;

   // =====================================================================
   // register indexes and bus address width
   localparam logic [11:0] IDX_CTRL0 = 12'h90c;
   localparam logic [11:0] IDX_CTRL1 = 12'h90d;
   localparam logic [11:0] IDX_CHSEL = 12'h90e;
   localparam logic [11:0] IDX_FBPIN = 12'h90f;
   localparam logic [11:0] IDX_HWOVR = 12'h910;
   localparam logic [11:0] IDX_TRIM = 12'h911;
   localparam logic [11:0] IDX_ORSRC = 12'h912;
   localparam int ADDR_W = 14;

   // =====================================================================
   // implemented-bit masks and reset values
   localparam logic [7:0] MASK_CTRL0 = 8'hab;
   localparam logic [7:0] MASK_CTRL1 = 8'h7f;
   localparam logic [7:0] MASK_CHSEL = 8'h77;
   localparam logic [7:0] MASK_FBPIN = 8'hc3;
   localparam logic [7:0] MASK_HWOVR = 8'hff;
   localparam logic [7:0] MASK_ORSRC = 8'h1f;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] TRIM_DEFAULT = 8'h80;

   // =====================================================================
   // field codes
   localparam logic [2:0] INV_SRC_GND = 3'h7;
   localparam logic [2:0] INV_SRC_PIN_MAX = 3'h3;
   localparam logic [2:0] INV_CH_NONE = 3'h0;
   localparam logic [2:0] INV_CH_LADDER = 3'h1;
   localparam logic [2:0] INV_CH_PIN = 3'h2;
   localparam logic [2:0] INV_CH_CONV1 = 3'h4;
   localparam logic [2:0] INV_CH_CONV2 = 3'h5;
   localparam logic [2:0] NINV_CH_GND = 3'h0;
   localparam logic [2:0] NINV_CH_LADDER = 3'h1;
   localparam logic [2:0] NINV_CH_PIN = 3'h2;
   localparam logic [2:0] NINV_CH_HALF = 3'h3;
   localparam logic [2:0] NINV_CH_CONV1 = 3'h4;
   localparam logic [2:0] NINV_CH_CONV2 = 3'h5;
   localparam logic [1:0] FB_MODE_NONE = 2'h0;
   localparam logic [1:0] FB_MODE_SUPPLY = 2'h1;
   localparam logic [1:0] FB_MODE_OUTPIN = 2'h2;
   localparam logic [2:0] HWC_USER = 3'h0;
   localparam logic [2:0] HWC_UNITY = 3'h4;
   localparam logic [2:0] HWC_RAIL = 3'h7;
   localparam logic [4:0] OVR_SRC_MAX = 5'h1a;
   localparam int OVR_SRC_N = 27;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // =====================================================================
   // analog switch controls, at most one set per group
   typedef struct packed {
      logic amp_enable;
      logic charge_pump_on;
      logic [3:0] inv_pin;     // inverting pins 3..0
      logic inv_pin_gnd;
      logic inv_none;
      logic inv_ladder;
      logic inv_pin_sel;
      logic inv_conv1;
      logic inv_conv2;
      logic inv_unity;
      logic [3:0] noninv_pin;
      logic noninv_gnd;
      logic noninv_ladder;
      logic noninv_pin_sel;
      logic noninv_half;
      logic noninv_conv1;
      logic noninv_conv2;
      logic fb_supply;
      logic fb_outpin;
      logic drive_supply;
      logic drive_ground;
      logic ladder_enable;
      logic [2:0] gain_ladder_select;
      logic [7:0] offset_trim;
   } oacrb_sw_s;
endpackage

//--- hdl/oacrb_top.sv
// Purpose: amplifier control register bank behind an axi4-lite slave
// Assumes: sys_clk 100 mhz, override sources come from other clock domains
// Notes: switch controls are registered, one cycle behind the decode
`timescale 1ns/1ps
`default_nettype none

// Operation
// - inverting pin source 111 selects ground, 000..011 select inverting pins 0..3, 100..110 reserved.
// - inverting channel 000 none, 001 gain ladder, 010 selected pin, 100 converter one, 101 converter two.
// - noninverting channel 000 ground, 001 ladder, 010 pin, 011 half supply, 100 and 101 converters.
// - feedback mode 00 open, 01 supply, 10 output pin, 11 reserved.
// - noninverting pin source 00..11 selects noninverting pins 0..3.
// - with override enabled the configuration comes from the hardware high and low fields.
// - high hardware config 000 user feedback, 100 unity gain, 111 drive to supply.
// - low hardware config 000 user feedback, 100 unity gain, 111 drive to ground.
// - override polarity set inverts the selected hardware control input.
// - override source 00000..11010 picks one of 27 inputs, higher codes are reserved.
// - offset trim loads the calibration value on the first enabled cycle after reset, writes replace it until next reset.
module oacrb_top #(
   parameter logic [7:0] TRIM_CAL = oacrb_pkg::TRIM_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [oacrb_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [oacrb_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [oacrb_pkg::OVR_SRC_N-1:0] override_inputs,
   output oacrb_pkg::oacrb_sw_s sw_ctrl,
   output logic override_level
);

   // =====================================================================
   // address decode, shared by read and write
   function automatic logic [2:0] reg_sel(input logic [oacrb_pkg::ADDR_W-1:0] a);
      logic [11:0] idx;
      idx = a[oacrb_pkg::ADDR_W-1:2];
      reg_sel = 3'h7;
      if (a[1:0] == 2'h0) begin
         unique case (idx)
            oacrb_pkg::IDX_CTRL0: reg_sel = 3'h0;
            oacrb_pkg::IDX_CTRL1: reg_sel = 3'h1;
            oacrb_pkg::IDX_CHSEL: reg_sel = 3'h2;
            oacrb_pkg::IDX_FBPIN: reg_sel = 3'h3;
            oacrb_pkg::IDX_HWOVR: reg_sel = 3'h4;
            oacrb_pkg::IDX_TRIM: reg_sel = 3'h5;
            oacrb_pkg::IDX_ORSRC: reg_sel = 3'h6;
            default: reg_sel = 3'h7;
         endcase
      end
   endfunction

   localparam logic [7:0] MASKS [0:6] = '{oacrb_pkg::MASK_CTRL0, oacrb_pkg::MASK_CTRL1,
      oacrb_pkg::MASK_CHSEL, oacrb_pkg::MASK_FBPIN, oacrb_pkg::MASK_HWOVR, 8'hff,
      oacrb_pkg::MASK_ORSRC};

   logic [7:0] regs_r [0:6];
   logic trim_loaded_r;

   // =====================================================================
   // write channel: address and data taken in either order
   logic aw_held_r, w_held_r;
   logic [oacrb_pkg::ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_byte_r;
   logic w_lane_r;
   logic aw_take, w_take, do_write;
   logic [2:0] wsel;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign do_write = clk_en && aw_held_r && w_held_r && !s_axi_bvalid;
   assign wsel = reg_sel(aw_addr_r);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= oacrb_pkg::AXI_OKAY;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !w_take && !s_axi_bvalid;
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 3'h7) ? oacrb_pkg::AXI_SLVERR : oacrb_pkg::AXI_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================================
   // register storage; masks keep unimplemented bits at zero
   for (genvar g = 0; g < 7; g++) begin : g_reg
      if (g != 5) begin : g_plain
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               regs_r[g] <= oacrb_pkg::RST_REG;
            end else if (clk_en && do_write && wsel == 3'(g) && w_lane_r) begin
               regs_r[g] <= w_byte_r & MASKS[g];
            end
         end
      end
   end

   // trim: reset constant, then calibration copied in after release so the
   // parameter never feeds an async reset path
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         regs_r[5] <= oacrb_pkg::RST_REG;
         trim_loaded_r <= 1'b0;
      end else if (clk_en) begin
         trim_loaded_r <= 1'b1;
         if (do_write && wsel == 3'h5 && w_lane_r) begin
            regs_r[5] <= w_byte_r;
         end else if (!trim_loaded_r) begin
            regs_r[5] <= TRIM_CAL;
         end
      end
   end

   // =====================================================================
   // read channel, one cycle answer
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= oacrb_pkg::AXI_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (reg_sel(s_axi_araddr) == 3'h7) begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= oacrb_pkg::AXI_SLVERR;
            end else begin
               s_axi_rdata <= {24'h00_0000, regs_r[reg_sel(s_axi_araddr)]};
               s_axi_rresp <= oacrb_pkg::AXI_OKAY;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =====================================================================
   // override input: synchronise all, then select
   logic [oacrb_pkg::OVR_SRC_N-1:0] ovr_meta_r, ovr_sync_r;
   logic [4:0] src_code;
   logic src_bit;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovr_meta_r <= '0;
         ovr_sync_r <= '0;
      end else if (clk_en) begin
         ovr_meta_r <= override_inputs;
         ovr_sync_r <= ovr_meta_r;
      end
   end

   assign src_code = regs_r[6][4:0];
   // reserved source codes read as a deasserted input
   assign src_bit = (src_code <= oacrb_pkg::OVR_SRC_MAX) ? ovr_sync_r[src_code] : 1'b0;

   // =====================================================================
   // configuration decode into one-hot switch controls
   oacrb_pkg::oacrb_sw_s sw_nxt;
   logic ovr_en, ovr_lvl;
   logic [2:0] hw_cfg, inv_src, inv_ch, ninv_ch;
   logic [1:0] soc, fb_mode, ninv_src;

   always_comb begin
      ovr_en = regs_r[4][7];
      ovr_lvl = src_bit ^ regs_r[4][3];
      hw_cfg = ovr_lvl ? regs_r[4][6:4] : regs_r[4][2:0];
      inv_src = regs_r[1][2:0];
      inv_ch = regs_r[2][6:4];
      ninv_ch = regs_r[2][2:0];
      fb_mode = regs_r[3][7:6];
      ninv_src = regs_r[3][1:0];
      soc = regs_r[0][1:0];
      sw_nxt = '0;
      sw_nxt.amp_enable = regs_r[0][7];
      sw_nxt.charge_pump_on = regs_r[0][5];
      sw_nxt.ladder_enable = regs_r[1][3];
      sw_nxt.gain_ladder_select = regs_r[1][6:4];
      sw_nxt.offset_trim = regs_r[5];
      sw_nxt.inv_pin_gnd = (inv_src == oacrb_pkg::INV_SRC_GND);
      if (inv_src <= oacrb_pkg::INV_SRC_PIN_MAX) begin
         sw_nxt.inv_pin[inv_src[1:0]] = 1'b1;
      end
      sw_nxt.noninv_pin[ninv_src] = 1'b1;
      // reserved channel codes leave that input open rather than guess a source
      unique case (inv_ch)
         oacrb_pkg::INV_CH_NONE: begin
            sw_nxt.inv_none = 1'b1;
         end
         oacrb_pkg::INV_CH_LADDER: begin
            sw_nxt.inv_ladder = 1'b1;
         end
         oacrb_pkg::INV_CH_PIN: begin
            sw_nxt.inv_pin_sel = 1'b1;
         end
         oacrb_pkg::INV_CH_CONV1: begin
            sw_nxt.inv_conv1 = 1'b1;
         end
         oacrb_pkg::INV_CH_CONV2: begin
            sw_nxt.inv_conv2 = 1'b1;
         end
         default: ;
      endcase
      unique case (ninv_ch)
         oacrb_pkg::NINV_CH_GND: begin
            sw_nxt.noninv_gnd = 1'b1;
         end
         oacrb_pkg::NINV_CH_LADDER: begin
            sw_nxt.noninv_ladder = 1'b1;
         end
         oacrb_pkg::NINV_CH_PIN: begin
            sw_nxt.noninv_pin_sel = 1'b1;
         end
         oacrb_pkg::NINV_CH_HALF: begin
            sw_nxt.noninv_half = 1'b1;
         end
         oacrb_pkg::NINV_CH_CONV1: begin
            sw_nxt.noninv_conv1 = 1'b1;
         end
         oacrb_pkg::NINV_CH_CONV2: begin
            sw_nxt.noninv_conv2 = 1'b1;
         end
         default: ;
      endcase
      unique case (fb_mode)
         oacrb_pkg::FB_MODE_NONE: begin
            // feedback path left open
         end
         oacrb_pkg::FB_MODE_SUPPLY: begin
            sw_nxt.fb_supply = 1'b1;
         end
         oacrb_pkg::FB_MODE_OUTPIN: begin
            sw_nxt.fb_outpin = 1'b1;
         end
         default: ;
      endcase
      if (ovr_en) begin
         sw_nxt.inv_unity = (hw_cfg == oacrb_pkg::HWC_UNITY);
         if (hw_cfg == oacrb_pkg::HWC_RAIL) begin
            sw_nxt.drive_supply = ovr_lvl;
            sw_nxt.drive_ground = !ovr_lvl;
         end
      end else begin
         sw_nxt.inv_unity = regs_r[0][3];
         sw_nxt.drive_supply = (soc == 2'h2);
         sw_nxt.drive_ground = (soc == 2'h1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_ctrl <= '0;
         override_level <= 1'b0;
      end else if (clk_en) begin
         sw_ctrl <= sw_nxt;
         override_level <= ovr_en && ovr_lvl;
      end
   end

endmodule
`default_nettype wire

//--- testbench/oacrb_sva.sv
// Purpose: concurrent checks on the amplifier register bank ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: switch groups are checked for exclusivity here, their values in the bench
`timescale 1ns/1ps
`default_nettype none
module oacrb_sva (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic s_axi_awready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire oacrb_pkg::oacrb_sw_s sw_ctrl
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // =====================================================================
   // bus handshakes
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
      else $error("read answer late");
   aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken during response");
   rdata_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   // =====================================================================
   // switch groups: a short between two sources would damage the analog side
   inv_pin_a: assert property ($onehot0({sw_ctrl.inv_pin, sw_ctrl.inv_pin_gnd}))
      else $error("inverting pins not exclusive");
   inv_chan_a: assert property ($onehot0({sw_ctrl.inv_none, sw_ctrl.inv_ladder,
      sw_ctrl.inv_pin_sel, sw_ctrl.inv_conv1, sw_ctrl.inv_conv2})) else $error("inv channel");
   noninv_chan_a: assert property ($onehot0({sw_ctrl.noninv_gnd, sw_ctrl.noninv_ladder,
      sw_ctrl.noninv_pin_sel, sw_ctrl.noninv_half, sw_ctrl.noninv_conv1, sw_ctrl.noninv_conv2}))
      else $error("noninverting channel not exclusive");
   fb_mode_a: assert property (!(sw_ctrl.fb_supply && sw_ctrl.fb_outpin))
      else $error("feedback to supply and output");
   noninv_pin_a: assert property ($onehot0(sw_ctrl.noninv_pin))
      else $error("noninverting pins not exclusive");
   rail_drive_a: assert property (!(sw_ctrl.drive_supply && sw_ctrl.drive_ground))
      else $error("output driven to both rails");
   wr_done_c: cover property (s_axi_bvalid && s_axi_bready);
   rd_done_c: cover property (s_axi_rvalid && s_axi_rready);
   rail_c: cover property ($rose(sw_ctrl.drive_supply));
endmodule
bind oacrb_top oacrb_sva i_oacrb_sva (.sys_clk, .arst_n, .clk_en, .s_axi_awready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .sw_ctrl);
`default_nettype wire

//--- testbench/oacrb_top_tb.sv
// Purpose: register and switch checks for the amplifier register bank
// Assumes: axi4-lite master in this file, override sources driven directly
// Notes: expected values are worked out from the field tables in the register bank header
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module oacrb_top_tb;
   localparam logic [7:0] CAL = 8'h5a;
   localparam logic [7:0] MSK [7] = '{8'hab, 8'h7f, 8'h77, 8'hc3, 8'hff, 8'hff, 8'h1f};
   logic sys_clk = 1'h0;
   logic arst_n = 1'h0;
   logic clk_en = 1'h1;
   logic [13:0] s_axi_awaddr = '0;
   logic [13:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [26:0] override_inputs = '0;
   logic override_level;
   oacrb_pkg::oacrb_sw_s sw;
   logic [4:0] ip;
   logic [5:0] np;
   int n_tests = 0;
   int bad_count = 0;
   int cycles = 0;
   assign ip = {sw.inv_none, sw.inv_ladder, sw.inv_pin_sel, sw.inv_conv1, sw.inv_conv2};
   assign np = {sw.noninv_gnd, sw.noninv_ladder, sw.noninv_pin_sel, sw.noninv_half,
      sw.noninv_conv1, sw.noninv_conv2};
   oacrb_top #(.TRIM_CAL(CAL)) i_oacrb_top (.sys_clk, .arst_n, .clk_en, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .override_inputs,
      .sw_ctrl(sw), .override_level);
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // =====================================================================
   // bus tasks: no cycle count assumed, a wait ends on its handshake or the timeout
   task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge sys_clk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      // ready raised only once the answer shows, so the hold check sees a stall
      do begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1 && !s_axi_bready) s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1));
      s_axi_bready <= 1'h0;
      `CHK(s_axi_bresp, er)
   endtask
   task automatic rd(input logic [11:0] idx, input logic [7:0] e, input logic [1:0] er);
      @(posedge sys_clk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1 && !s_axi_rready) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1));
      s_axi_rready <= 1'h0;
      `CHK({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e})
   endtask
   task automatic rst();
      arst_n <= 1'h0;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'h1;
      repeat (2) @(posedge sys_clk);
   endtask
   // only the chosen source follows v, the rest take the opposite level
   task automatic ovr(input logic [4:0] src, input logic [7:0] hwc, input logic v,
         input logic [3:0] m, input logic [3:0] e);
      wr(oacrb_pkg::IDX_ORSRC, {3'h0, src}, 2'h0);
      wr(oacrb_pkg::IDX_HWOVR, hwc, 2'h0);
      override_inputs <= v ? 27'h1 << src : ~(27'h1 << src);
      repeat (6) @(posedge sys_clk);
      `CHK({override_level, sw.drive_supply, sw.drive_ground, sw.inv_unity} & m, e)
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   // =====================================================================
   // tests
   initial begin
      rst();
      for (int i = 0; i < 7; i++) rd(oacrb_pkg::IDX_CTRL0 + 12'(i), (i == 5) ? CAL : 8'h0, 2'h0);
      for (int i = 0; i < 7; i++) begin
         wr(oacrb_pkg::IDX_CTRL0 + 12'(i), 8'hff, 2'h0);
         rd(oacrb_pkg::IDX_CTRL0 + 12'(i), MSK[i], 2'h0);
      end
      wr(oacrb_pkg::IDX_TRIM, 8'h33, 2'h0);
      rd(oacrb_pkg::IDX_TRIM, 8'h33, 2'h0);
      `CHK(sw.offset_trim, 8'h33)
      wr(12'h90b, 8'h01, 2'h2);
      rd(12'h913, 8'h00, 2'h2);
      rst();
      rd(oacrb_pkg::IDX_TRIM, CAL, 2'h0);
      `CHK(sw.offset_trim, CAL)
      $display("test registers done");
      wr(oacrb_pkg::IDX_CTRL0, 8'h80, 2'h0);
      for (int c = 0; c < 8; c++) begin
         wr(oacrb_pkg::IDX_CHSEL, 8'(c * 17), 2'h0);
         repeat (2) @(posedge sys_clk);
         `CHK(ip, 5'(c < 3 ? 16 >> c : c == 4 ? 2 : c == 5 ? 1 : 0))
         `CHK(np, 6'(c < 6 ? 32 >> c : 0))
      end
      $display("test channels done");
      wr(oacrb_pkg::IDX_CHSEL, 8'h22, 2'h0);
      for (int c = 0; c < 8; c++) begin
         wr(oacrb_pkg::IDX_CTRL1, 8'(c), 2'h0);
         if (c < 4) wr(oacrb_pkg::IDX_FBPIN, 8'(c * 65), 2'h0);
         // switch outputs lag the register by one cycle, so let two edges pass
         repeat (2) @(posedge sys_clk);
         `CHK({sw.inv_pin, sw.inv_pin_gnd}, {4'(c < 4 ? 1 << c : 0), c == 7})
         if (c < 4) begin
            `CHK({sw.fb_supply, sw.fb_outpin}, {c == 1, c == 2})
            `CHK(sw.noninv_pin, 4'(1 << c))
         end
      end
      $display("test pins done");
      ovr(5'h05, 8'hf7, 1'h1, 4'he, 4'hc);
      // a low clock enable must freeze the synchronisers and the level output
      clk_en <= 1'h0;
      override_inputs <= 27'h0;
      repeat (6) @(posedge sys_clk);
      `CHK(override_level, 1'h1)
      clk_en <= 1'h1;
      repeat (6) @(posedge sys_clk);
      `CHK(override_level, 1'h0)
      ovr(5'h05, 8'hf7, 1'h0, 4'he, 4'h2);
      ovr(5'h05, 8'hff, 1'h0, 4'he, 4'hc);
      ovr(5'h00, 8'hff, 1'h1, 4'he, 4'h2);
      ovr(5'h1a, 8'hc0, 1'h1, 4'hf, 4'h9);
      ovr(5'h1a, 8'hc0, 1'h0, 4'hf, 4'h0);
      ovr(5'h1b, 8'hf7, 1'h0, 4'he, 4'h2);
      ovr(5'h05, 8'h77, 1'h1, 4'he, 4'h0);
      $display("test override done");
      stop_test();
   end
endmodule
`default_nettype wire
